// >>> src/pwm_velocity_torque_decoder.sv
/*
 * Velocity and torque command decoder for the digital command inputs.
 * Assumes register strobes one cycle long and pins driven by a controller.
 */
// Decided for this implementation: strobed register access and the placing of the registers.
// Function
// - Bipolar: duty below half commands clockwise speed, maximum near zero duty.
// - Bipolar: duty above half commands counterclockwise speed, zero near half.
// - Bipolar: static low or high input gives zero velocity.
// - Duty within plus or minus deadband of half commands zero.
// - Remaining duty span beyond deadband is scaled to full velocity.
// - Velocity approaches each new target at the configured acceleration.
// - Torque level mode: A low uses standard, A high alternate limit.
// - Torque PWM mode: static low standard, static high alternate, else blend.
// - No activity for 50 ms declares input off, zero velocity.
// - Energize while enable high, de-energize within 10 ms of release.
// - Enable low means no motion from any other input.
// - Unipolar: speed proportional to duty, zero at zero duty.
// - Unipolar: static low or high input means absent, zero velocity.
// - Unipolar and frequency: A high clockwise, A low counterclockwise.
// - Frequency mode: speed rises in proportion to input B frequency.
// - Inhibit variant: A high ramps velocity to zero overriding B.
// - Frequency speed is max times (f minus fmin) over (fmax minus fmin).
`timescale 1ns/1ps
module pwm_velocity_torque_decoder #(
    parameter int TIMEOUT = vel_cmd_pkg::TIMEOUT_CYC,
    parameter int GATE    = vel_cmd_pkg::GATE_CYC
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Register port
    input  vel_cmd_pkg::reg_req_s        req,
    output logic [31:0]                  rdata,
    // Command pins
    input  wire logic                    enable_in,
    input  wire logic                    input_a,
    input  wire logic                    input_b,
    // Motor command
    output vel_cmd_pkg::motor_cmd_s      motor
);
    import vel_cmd_pkg::*;

    typedef struct packed {
        mode_e        mode;
        logic [15:0]  maxv;
        logic [15:0]  dead;
        logic [15:0]  accel;
        logic [15:0]  tq_std;
        logic [15:0]  tq_alt;
        logic [15:0]  fmin;
        logic [15:0]  fmax;
        calc_e        cst;
        logic [1:0]   op;
        logic [5:0]   bitn;
        logic [47:0]  num;
        logic [24:0]  rem;
        logic [23:0]  den;
        logic [15:0]  duty_a;
        logic [15:0]  duty_b;
        logic [15:0]  mag;
        logic         cw;
        logic [23:0]  gcnt;
        logic [15:0]  gedge;
        logic [15:0]  freq;
        logic [7:0]   tick;
        logic         short_a;
        logic         short_b;
        logic [31:0]  rdata;
        motor_cmd_s   mot;
    } core_s;

    core_s r;
    core_s n;
    meas_s ma;
    meas_s mb;

    logic               dir;
    logic               okv;
    logic signed [16:0] tgt;
    logic signed [17:0] vx;
    logic signed [17:0] tx;
    logic signed [17:0] up;
    logic signed [17:0] dn;
    logic [24:0]        rem_sh;
    logic               ge;
    logic [15:0]        q16;
    logic [15:0]        qv;
    logic [15:0]        fx;
    logic [15:0]        ad;
    logic [31:0]        prod_u;
    logic [32:0]        blend;
    logic [31:0]        prod_f;
    logic [15:0]        ad_x;
    logic [31:0]        prod_d;
    logic [16:0]        inv_a;
    logic [32:0]        p_std;
    logic [32:0]        p_alt;
    logic               stat_clr;

    pwm_meter #(.TIMEOUT(TIMEOUT)) u_meter_a (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (input_a),
        .meas  (ma)
    );

    pwm_meter #(.TIMEOUT(TIMEOUT)) u_meter_b (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (input_b),
        .meas  (mb)
    );

    assign rdata = r.rdata;
    assign motor = r.mot;

    always_comb begin
        n        = r;
        n.rdata  = '0;
        stat_clr = req.wr && (req.addr == R_STAT);

        // Configuration writes; a mode code that is not one-hot is ignored
        if (req.wr) begin
            case (req.addr)
                R_CTRL: begin
                    if ($onehot(req.wdata[4:0])) begin
                        n.mode = mode_e'(req.wdata[4:0]);
                    end
                end
                R_MAXV:   n.maxv   = req.wdata[15:0];
                R_DEAD:   n.dead   = req.wdata[15:0];
                R_ACCEL:  n.accel  = req.wdata[15:0];
                R_TQ_STD: n.tq_std = req.wdata[15:0];
                R_TQ_ALT: n.tq_alt = req.wdata[15:0];
                R_FMIN:   n.fmin   = req.wdata[15:0];
                R_FMAX:   n.fmax   = req.wdata[15:0];
                default: ;
            endcase
        end

        if (req.rd) begin
            case (req.addr)
                R_CTRL:   n.rdata = {27'h0, r.mode};
                R_MAXV:   n.rdata = {16'h0, r.maxv};
                R_DEAD:   n.rdata = {16'h0, r.dead};
                R_ACCEL:  n.rdata = {16'h0, r.accel};
                R_TQ_STD: n.rdata = {16'h0, r.tq_std};
                R_TQ_ALT: n.rdata = {16'h0, r.tq_alt};
                R_FMIN:   n.rdata = {16'h0, r.fmin};
                R_FMAX:   n.rdata = {16'h0, r.fmax};
                R_STAT:   n.rdata = {27'h0, r.short_a, r.short_b, ma.active, mb.active, r.mot.energized};
                R_VEL:    n.rdata = {{15{r.mot.velocity[16]}}, r.mot.velocity};
                R_DUTY:   n.rdata = {r.duty_a, r.duty_b};
                R_FREQ:   n.rdata = {16'h0, r.freq};
                default:  n.rdata = '0;
            endcase
        end

        // Sticky short-phase flags: a new event beats the clear
        n.short_a = (r.short_a & ~(stat_clr & req.wdata[ST_SHORT_A])) | ma.short_ph;
        n.short_b = (r.short_b & ~(stat_clr & req.wdata[ST_SHORT_B])) | mb.short_ph;

        // Frequency gate: rising edges of B per gate window
        if (r.gcnt == 24'(GATE - 1)) begin
            n.gcnt  = '0;
            n.freq  = r.gedge + {15'h0, mb.rise};
            n.gedge = '0;
        end else begin
            n.gcnt  = r.gcnt + 1'b1;
            n.gedge = r.gedge + {15'h0, mb.rise};
        end

        // Shared divider helpers
        rem_sh = {r.rem[23:0], r.num[47]};
        ge     = rem_sh >= {1'b0, r.den};
        q16    = (|r.num[47:16]) ? 16'hffff : r.num[15:0];
        qv     = ((|r.num[47:16]) || (r.num[15:0] > r.maxv)) ? r.maxv : r.num[15:0];
        fx     = (r.freq > r.fmin) ? (r.freq - r.fmin) : 16'h0;
        ad     = (q16 < DUTY_HALF) ? (DUTY_HALF - q16) : (q16 - DUTY_HALF);
        prod_u = q16 * r.maxv;
        // Products kept at full width; a narrow concatenation would cut them
        prod_f = fx * r.maxv;
        ad_x   = ad - r.dead;
        prod_d = ad_x * r.maxv;

        case (r.cst)
            C_IDLE: begin
                n.cst  = C_DIV;
                n.bitn = '0;
                n.rem  = '0;
                if (r.op == OP_A) begin
                    n.num = {8'h0, ma.high, 16'h0};
                    n.den = ma.period;
                end else if (r.mode == M_FREQ) begin
                    n.num = {16'h0, prod_f};
                    n.den = {8'h0, r.fmax - r.fmin};
                end else begin
                    n.num = {8'h0, mb.high, 16'h0};
                    n.den = mb.period;
                end
            end
            C_DIV: begin
                n.rem  = ge ? (rem_sh - {1'b0, r.den}) : rem_sh;
                n.num  = {r.num[46:0], ge};
                n.bitn = r.bitn + 1'b1;
                if (r.bitn == 6'(DIV_STEPS - 1)) begin
                    n.cst = C_POST;
                end
            end
            C_POST: begin
                n.cst = C_IDLE;
                case (r.op)
                    OP_B: begin
                        n.op = OP_A;
                        if (r.mode == M_FREQ) begin
                            n.mag = qv;
                        end else begin
                            n.duty_b = q16;
                            if (r.mode == M_UNI) begin
                                n.mag = prod_u[31:16];
                            end else begin
                                n.cw = q16 < DUTY_HALF;
                                if (ad <= r.dead) begin
                                    n.mag = '0;
                                end else begin
                                    // Rescale what lies outside the deadband
                                    n.num  = {16'h0, prod_d};
                                    n.den  = {8'h0, DUTY_HALF - r.dead};
                                    n.rem  = '0;
                                    n.bitn = '0;
                                    n.op   = OP_S;
                                    n.cst  = C_DIV;
                                end
                            end
                        end
                    end
                    OP_S: begin
                        n.mag = qv;
                        n.op  = OP_A;
                    end
                    default: begin
                        n.duty_a = q16;
                        n.op     = OP_B;
                    end
                endcase
            end
            default: n.cst = C_IDLE;
        endcase

        // Torque limit selection
        // Weights sum to exactly 1.0, so half duty lands midway
        inv_a = 17'h10000 - {1'b0, r.duty_a};
        p_std = r.tq_std * inv_a;
        p_alt = r.tq_alt * r.duty_a;
        blend = p_std + p_alt;
        if (r.mode == M_BI_TQL) begin
            n.mot.torque = ma.level ? r.tq_alt : r.tq_std;
        end else if (r.mode == M_BI_TQP) begin
            if (!ma.active) begin
                n.mot.torque = ma.level ? r.tq_alt : r.tq_std;
            end else begin
                n.mot.torque = blend[31:16];
            end
        end else begin
            n.mot.torque = r.tq_std;
        end

        // Target velocity; clockwise is positive
        dir = ((r.mode == M_UNI) || (r.mode == M_FREQ)) ? ma.level : r.cw;
        okv = enable_in && mb.active && !((r.mode == M_BI_INH) && ma.level);
        if (!okv) begin
            tgt = '0;
        end else if (dir) begin
            tgt = $signed({1'b0, r.mag});
        end else begin
            tgt = -$signed({1'b0, r.mag});
        end

        // Acceleration-limited ramp
        vx = {r.mot.velocity[16], r.mot.velocity};
        tx = {tgt[16], tgt};
        up = vx + $signed({2'b0, r.accel});
        dn = vx - $signed({2'b0, r.accel});
        if (r.tick == 8'(RAMP_CYC - 1)) begin
            n.tick = '0;
        end else begin
            n.tick = r.tick + 1'b1;
        end
        if (!enable_in) begin
            n.mot.velocity = '0;
        end else if (r.tick == 8'(RAMP_CYC - 1)) begin
            if (vx < tx) begin
                n.mot.velocity = (up > tx) ? tgt : up[16:0];
            end else if (vx > tx) begin
                n.mot.velocity = (dn < tx) ? tgt : dn[16:0];
            end
        end
        // Drop power at once on release, far inside the disable time
        n.mot.energized = enable_in;
        n.mot.high_level_feedback_output = enable_in && (r.mot.velocity == tgt);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r        <= '0;
            r.mode   <= M_BI_INH;
            r.maxv   <= MAXV_RST;
            r.dead   <= DEAD_RST;
            r.accel  <= ACCEL_RST;
            r.tq_std <= TQ_STD_RST;
            r.tq_alt <= TQ_ALT_RST;
            r.fmin   <= FMIN_RST;
            r.fmax   <= FMAX_RST;
            r.cst    <= C_IDLE;
            r.op     <= OP_B;
            r.mot.torque <= TQ_STD_RST;
        end else begin
            r <= n;
        end
    end

    // Checks
    property p_disable;
        @(posedge clk) disable iff (!rst_n) !enable_in |=> !motor.energized;
    endproperty
    a_disable: assert property (p_disable) else $error("energized after enable low");

    property p_no_motion;
        @(posedge clk) disable iff (!rst_n) !enable_in |=> (motor.velocity == 17'h0);
    endproperty
    a_no_motion: assert property (p_no_motion) else $error("velocity while disabled");

    property p_inactive_zero;
        @(posedge clk) disable iff (!rst_n) !mb.active |-> (tgt == 17'sh0);
    endproperty
    a_inactive_zero: assert property (p_inactive_zero) else $error("target without B activity");

    property p_inhibit;
        @(posedge clk) disable iff (!rst_n) (r.mode == M_BI_INH) && ma.level |-> (tgt == 17'sh0);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit ignored");

    property p_ramp;
        @(posedge clk) disable iff (!rst_n)
            enable_in && $past(enable_in) |-> ((vx - $past(vx)) <= $signed({2'b0, $past(r.accel)}))
                && (($past(vx) - vx) <= $signed({2'b0, $past(r.accel)}));
    endproperty
    a_ramp: assert property (p_ramp) else $error("velocity step above acceleration");

    property p_tq_level;
        @(posedge clk) disable iff (!rst_n)
            (r.mode == M_BI_TQL) && ma.level && $stable(r.mode) |=> (motor.torque == $past(r.tq_alt));
    endproperty
    a_tq_level: assert property (p_tq_level) else $error("level torque not alternate");

    property p_dead;
        @(posedge clk) disable iff (!rst_n)
            (r.cst == C_POST) && (r.op == OP_B) && (r.mode != M_UNI) && (r.mode != M_FREQ)
                && (ad <= r.dead) |=> (r.mag == 16'h0);
    endproperty
    a_dead: assert property (p_dead) else $error("deadband not zero");

    property p_mode_onehot;
        @(posedge clk) disable iff (!rst_n) $onehot(r.mode);
    endproperty
    a_mode_onehot: assert property (p_mode_onehot) else $error("mode not one-hot");

    property p_uni_dir;
        @(posedge clk) disable iff (!rst_n)
            (r.mode == M_UNI) && (tgt != 17'sh0) |-> ((tgt > 17'sh0) == ma.level);
    endproperty
    a_uni_dir: assert property (p_uni_dir) else $error("unipolar direction wrong");

    c_bipolar_run: cover property (@(posedge clk) disable iff (!rst_n) (r.mode == M_BI_INH) && (tgt != 17'sh0));
    c_freq_run:    cover property (@(posedge clk) disable iff (!rst_n) (r.mode == M_FREQ) && (r.mag != 16'h0));
    c_tq_blend:    cover property (@(posedge clk) disable iff (!rst_n) (r.mode == M_BI_TQP) && ma.active);

endmodule : pwm_velocity_torque_decoder

// >>> src/vel_cmd_pkg.sv
/*
 * Shared constants, register map, modes and carrier structs for the
 * velocity/torque command decoder.
 * Assumes a single 200 MHz clock and a synchronous active-low reset.
 */
package vel_cmd_pkg;

    // Clock and timing
    localparam int CLK_MHZ       = 200;
    localparam int TIMEOUT_MS    = 50;
    localparam int TIMEOUT_CYC   = TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int MIN_PULSE_NS  = 300;
    localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int DISABLE_MS    = 10;
    localparam int DISABLE_CYC   = DISABLE_MS * CLK_MHZ * 1000;
    localparam int GATE_MS       = 10;
    localparam int GATE_CYC      = GATE_MS * CLK_MHZ * 1000;
    localparam int RAMP_US       = 1;
    localparam int RAMP_CYC      = RAMP_US * CLK_MHZ;

    // Arithmetic
    localparam int          CNT_W     = 24;
    localparam int          DIV_STEPS = 48;
    localparam logic [15:0] DUTY_HALF = 16'h8000;

    // Register indices
    localparam logic [3:0] R_CTRL   = 4'h0;
    localparam logic [3:0] R_MAXV   = 4'h1;
    localparam logic [3:0] R_DEAD   = 4'h2;
    localparam logic [3:0] R_ACCEL  = 4'h3;
    localparam logic [3:0] R_TQ_STD = 4'h4;
    localparam logic [3:0] R_TQ_ALT = 4'h5;
    localparam logic [3:0] R_FMIN   = 4'h6;
    localparam logic [3:0] R_FMAX   = 4'h7;
    localparam logic [3:0] R_STAT   = 4'h8;
    localparam logic [3:0] R_VEL    = 4'h9;
    localparam logic [3:0] R_DUTY   = 4'ha;
    localparam logic [3:0] R_FREQ   = 4'hb;

    // Status bit positions
    localparam int ST_ENERG   = 0;
    localparam int ST_ACT_B   = 1;
    localparam int ST_ACT_A   = 2;
    localparam int ST_SHORT_B = 3;
    localparam int ST_SHORT_A = 4;

    // Reset values
    localparam logic [15:0] MAXV_RST   = 16'h1000;
    localparam logic [15:0] DEAD_RST   = 16'h0000;
    localparam logic [15:0] ACCEL_RST  = 16'h0001;
    localparam logic [15:0] TQ_STD_RST = 16'h8000;
    localparam logic [15:0] TQ_ALT_RST = 16'h4000;
    localparam logic [15:0] FMIN_RST   = 16'h0000;
    localparam logic [15:0] FMAX_RST   = 16'h1388;

    typedef enum logic [4:0] {
        M_BI_INH = 5'b00001,
        M_BI_TQL = 5'b00010,
        M_BI_TQP = 5'b00100,
        M_UNI    = 5'b01000,
        M_FREQ   = 5'b10000
    } mode_e;

    typedef enum logic [2:0] {
        C_IDLE = 3'b001,
        C_DIV  = 3'b010,
        C_POST = 3'b100
    } calc_e;

    localparam logic [1:0] OP_B = 2'h0;
    localparam logic [1:0] OP_S = 2'h1;
    localparam logic [1:0] OP_A = 2'h2;

    typedef struct packed {
        logic             level;
        logic             active;
        logic             rise;
        logic             short_ph;
        logic [CNT_W-1:0] high;
        logic [CNT_W-1:0] period;
    } meas_s;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    typedef struct packed {
        logic        energized;
        logic        high_level_feedback_output;
        logic [16:0] velocity;
        logic [15:0] torque;
    } motor_cmd_s;

endpackage : vel_cmd_pkg

// >>> src/pwm_meter.sv
/*
 * Phase meter for one command input: two-stage synchroniser, high and
 * period measurement, rising-edge pulse, activity timeout, short-phase flag.
 * Assumes the pin is asynchronous to clk.
 */
`timescale 1ns/1ps
module pwm_meter #(
    parameter int TIMEOUT = vel_cmd_pkg::TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Pin and result
    input  wire logic               pin,
    output vel_cmd_pkg::meas_s      meas
);
    import vel_cmd_pkg::*;

    typedef struct packed {
        logic             s1;
        logic             s2;
        logic             prev;
        logic             got_fall;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] idle;
        logic [CNT_W-1:0] high;
        meas_s            m;
    } mst_s;

    mst_s r;
    mst_s n;
    logic rise;
    logic fall;

    assign meas = r.m;

    always_comb begin
        n          = r;
        n.s1       = pin;
        n.s2       = r.s1;
        n.prev     = r.s2;
        n.m.level  = r.s2;
        n.m.rise   = 1'b0;
        n.m.short_ph = 1'b0;
        rise       = r.s2 & ~r.prev;
        fall       = ~r.s2 & r.prev;
        if (r.cnt != '1) begin
            n.cnt = r.cnt + 1'b1;
        end
        if (rise | fall) begin
            n.idle = '0;
            // Phases below the resolvable width are flagged
            n.m.short_ph = (r.idle < CNT_W'(MIN_PULSE_CYC - 1));
        end else if (r.idle != CNT_W'(TIMEOUT)) begin
            n.idle = r.idle + 1'b1;
        end else begin
            n.m.active = 1'b0;
            n.got_fall = 1'b0;
        end
        if (fall) begin
            n.high     = r.cnt + 1'b1;
            n.got_fall = 1'b1;
        end
        if (rise) begin
            n.m.rise = 1'b1;
            n.cnt    = '0;
            if (r.got_fall) begin
                n.m.high   = r.high;
                n.m.period = r.cnt + 1'b1;
                n.m.active = 1'b1;
            end
            n.got_fall = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule : pwm_meter

// >>> tb/pwm_src.sv
/*
 * Controller model: drives one command pin as PWM or as a static level.
 * Assumes the bench clock; period and high time are counted in its cycles.
 */
`timescale 1ns/1ps
module pwm_src (
    // Clock
    input  wire logic        clk,
    // Waveform: high 0 is static low, high >= period static high
    input  wire logic [15:0] period,
    input  wire logic [15:0] high,
    // Pin
    output logic             pin
);
    logic [15:0] cnt = 16'h0000;

    // Bench keeps every phase at least 60 cycles; periods are scaled with the timeout
    always @(posedge clk) begin
        cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
        pin <= (cnt < high);
    end
endmodule : pwm_src

// >>> tb/tb_top.sv
/*
 * Testbench for the velocity and torque command decoder.
 * Assumes shortened timeout and gate counts; two controller models drive A and B.
 */
`timescale 1ns/1ps
module tb_top;
    import vel_cmd_pkg::*;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        en = 1'b0;
    reg_req_s    req = '0;
    logic [31:0] rdata;
    logic [15:0] pa = 16'h0000, ha = 16'h0000, pb = 16'h0000, hb = 16'h0000;
    logic        a;
    logic        b;
    motor_cmd_s  motor;
    int          fail_count = 0;
    int          checks = 0;

    always #2.5 clk = ~clk;

    pwm_src pwm_src_a_i (.clk(clk), .period(pa), .high(ha), .pin(a));
    pwm_src pwm_src_b_i (.clk(clk), .period(pb), .high(hb), .pin(b));

    pwm_velocity_torque_decoder #(.TIMEOUT(2000), .GATE(2000)) pwm_velocity_torque_decoder_i (
        .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .enable_in(en),
        .input_a(a), .input_b(b), .motor(motor));

    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        checks++;
        if (got !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, e);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    // Settles past timeout and gate, then waits for the ramp to finish
    task automatic chk_vel(input logic [16:0] e);
        int n;
        n = 0;
        idle(5000);
        while (motor.high_level_feedback_output !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        checks++;
        if (motor.velocity !== e || motor.high_level_feedback_output !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: velocity %h feedback %b expected %h", $time, motor.velocity,
                     motor.high_level_feedback_output, e);
        end
    endtask : chk_vel

    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk);
        req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] ad, input logic [31:0] e);
        @(posedge clk);
        req <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd

    task automatic wave(input logic [15:0] p1, h1, p2, h2);
        @(posedge clk);
        pa <= p1;
        ha <= h1;
        pb <= p2;
        hb <= h2;
    endtask : wave

    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        en    <= 1'b1;
        rd(R_CTRL, 32'h1);
        rd(R_MAXV, 32'h1000);
        rd(R_TQ_ALT, 32'h4000);
        rd(4'hc, 32'h0);
        wr(R_CTRL, 32'h3);
        rd(R_CTRL, 32'h1);
        wr(R_ACCEL, 32'h100);
        $display("register tests done");
        wave(0, 0, 400, 100);
        chk_vel(17'h00800);
        wave(0, 0, 400, 300);
        chk_vel(17'h1f800);
        wave(0, 0, 400, 400);
        chk_vel(17'h00000);
        wave(0, 0, 400, 100);
        chk_vel(17'h00800);
        wave(2, 2, 400, 100);
        chk_vel(17'h00000);
        wr(R_DEAD, 32'h4000);
        wave(0, 0, 800, 100);
        chk_vel(17'h00800);
        wave(0, 0, 800, 300);
        chk_vel(17'h00000);
        wr(R_DEAD, 32'h0);
        $display("bipolar tests done");
        wr(R_CTRL, 32'h8);
        wave(2, 2, 400, 100);
        chk_vel(17'h00400);
        rd(R_VEL, 32'h400);
        wave(0, 0, 400, 100);
        chk_vel(17'h1fc00);
        wave(0, 0, 400, 400);
        chk_vel(17'h00000);
        $display("unipolar tests done");
        wr(R_CTRL, 32'h2);
        idle(100);
        chk({16'h0, motor.torque}, 32'h8000);
        wave(2, 2, 400, 400);
        idle(100);
        chk({16'h0, motor.torque}, 32'h4000);
        wr(R_CTRL, 32'h4);
        wave(400, 200, 400, 400);
        idle(1500);
        chk({16'h0, motor.torque}, 32'h6000);
        wave(0, 0, 400, 400);
        idle(2600);
        chk({16'h0, motor.torque}, 32'h8000);
        $display("torque tests done");
        wr(R_FMAX, 32'h8);
        wr(R_CTRL, 32'h10);
        wave(2, 2, 500, 250);
        chk_vel(17'h00800);
        rd(R_FREQ, 32'h4);
        $display("frequency tests done");
        @(posedge clk);
        en <= 1'b0;
        idle(3);
        chk({15'h0, motor.velocity}, 32'h0);
        chk({31'h0, motor.energized}, 32'h0);
        $display("enable tests done");
        end_sim();
    end
endmodule : tb_top
